/* pkg/ied_pkg.sv */
// Constants for the inertial event detector: register map, fields, reset values.
package ied_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_PIN_CONTROL = 8'h22;
    localparam logic [7:0] ADDR_HP_RECOVER = 8'h23;
    localparam logic [7:0] ADDR_X_SAMPLE = 8'h29;
    localparam logic [7:0] ADDR_Y_SAMPLE = 8'h2b;
    localparam logic [7:0] ADDR_Z_SAMPLE = 8'h2d;
    localparam logic [7:0] ADDR_EVENT_CONFIG = 8'h30;
    localparam logic [7:0] ADDR_EVENT_SOURCE = 8'h31;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h32;
    localparam logic [7:0] ADDR_MIN_DURATION = 8'h33;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Configuration fields
    localparam int CFG_COMBINE_BIT = 7;
    localparam int CFG_LATCH_BIT = 6;
    // Threshold fields
    localparam int THS_MODE_BIT = 7;
    localparam int THS_VALUE_MSB = 6;
    // Source fields
    localparam int SRC_ACTIVE_BIT = 6;
    // Pin routing fields
    localparam int ROUTE_PIN1_LSB = 0;
    localparam int ROUTE_PIN2_LSB = 3;
    localparam int ROUTE_WIDTH = 3;
    localparam int NUM_AXES = 3;
    // Pin routing codes
    localparam logic [2:0] ROUTE_GROUND = 3'h0;
    localparam logic [2:0] ROUTE_SOURCE1 = 3'h1;
    localparam logic [2:0] ROUTE_SOURCE2 = 3'h2;
    localparam logic [2:0] ROUTE_EITHER = 3'h3;
    localparam logic [2:0] ROUTE_DATA_READY = 3'h4;
    // Duration step per output sample, 100 ns clock
    localparam real DURATION_STEP_FAST_MS = 2.5;
    localparam real DURATION_STEP_SLOW_MS = 10.0;
    localparam real CLOCK_PERIOD_NS = 100.0;
    localparam int DURATION_STEP_FAST_CYC = int'(DURATION_STEP_FAST_MS * 1.0e6 / CLOCK_PERIOD_NS);
    localparam int DURATION_STEP_SLOW_CYC = int'(DURATION_STEP_SLOW_MS * 1.0e6 / CLOCK_PERIOD_NS);
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
endpackage

/* logic/ied_inertial_event_detector.sv */
// Inertial event source 1, axis sample registers and high-pass recovery.
`timescale 1ns/1ps

module ied_inertial_event_detector
    import ied_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host register port, already decoded from the serial front end
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Sample stream, one pulse per output sample period
    input wire logic sampleTick,
    input wire logic [7:0] xSample,
    input wire logic [7:0] ySample,
    input wire logic [7:0] zSample,
    // Use filtered data for event detection
    input wire logic hpForEvents,
    // Other interrupt sources for pin routing
    input wire logic source2Irq,
    input wire logic dataReady,
    // Filtered axis data
    output logic [7:0] xFiltered,
    output logic [7:0] yFiltered,
    output logic [7:0] zFiltered,
    // Interrupt request of this source and the two pins
    output logic inertialIrqOne,
    output logic irqPin1,
    output logic irqPin2
);

    // Unsigned magnitude of a two's complement sample
    function automatic logic [7:0] magnitude(input logic [7:0] v);
        logic [7:0] neg;
        neg = 8'(~v + COUNT_ONE);
        return v[7] ? neg : v;
    endfunction

    // Pin routing decode, used for both pins
    function automatic logic routePin(input logic [2:0] sel, input logic src1,
                                      input logic src2, input logic drdy);
        logic r;
        r = 1'b0;
        case (sel)
            ROUTE_GROUND: r = 1'b0;
            ROUTE_SOURCE1: r = src1;
            ROUTE_SOURCE2: r = src2;
            ROUTE_EITHER: r = src1 | src2;
            ROUTE_DATA_READY: r = drdy;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Register read strobes
    wire logic readSource = regRead && (regAddr == ADDR_EVENT_SOURCE);
    wire logic readRecover = regRead && (regAddr == ADDR_HP_RECOVER);

    // Writable registers
    logic [7:0] configReg_q, configReg_d; // Combine, latch, enables
    logic [7:0] thresholdReg_q, thresholdReg_d; // Mode bit and threshold
    logic [7:0] durationReg_q, durationReg_d; // Minimum event duration
    logic [7:0] pinControl_q, pinControl_d; // Pin routing fields

    // Config write path
    always_comb begin
        configReg_d = configReg_q;
        thresholdReg_d = thresholdReg_q;
        durationReg_d = durationReg_q;
        pinControl_d = pinControl_q;
        if (regWrite) begin
            case (regAddr)
                ADDR_EVENT_CONFIG: configReg_d = regWdata;
                ADDR_THRESHOLD: thresholdReg_d = regWdata;
                ADDR_MIN_DURATION: durationReg_d = regWdata;
                ADDR_PIN_CONTROL: pinControl_d = regWdata;
                default: configReg_d = configReg_q; // Read-only or unmapped: ignored
            endcase
        end
    end

    // Config registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            configReg_q <= RESET_BYTE;
            thresholdReg_q <= RESET_BYTE;
            durationReg_q <= RESET_BYTE;
            pinControl_q <= RESET_BYTE;
        end else begin
            configReg_q <= configReg_d;
            thresholdReg_q <= thresholdReg_d;
            durationReg_q <= durationReg_d;
            pinControl_q <= pinControl_d;
        end
    end

    // Per-axis storage, index 0 is X
    logic [7:0] rawIn [NUM_AXES];
    logic [7:0] sample_q [NUM_AXES]; // Latest raw sample
    logic [7:0] sample_d [NUM_AXES];
    logic [7:0] hpRef_q [NUM_AXES]; // Filter DC reference
    logic [7:0] hpRef_d [NUM_AXES];
    logic [7:0] hpOut_q [NUM_AXES]; // Filter output
    logic [7:0] hpOut_d [NUM_AXES];
    logic [7:0] detectIn [NUM_AXES]; // Data feeding the comparators
    logic [NUM_AXES-1:0] axisHigh; // Per-axis high condition
    logic [NUM_AXES-1:0] axisLow; // Per-axis low condition

    assign rawIn[0] = xSample;
    assign rawIn[1] = ySample;
    assign rawIn[2] = zSample;

    // Threshold zero-extended to sample width
    wire logic [7:0] thresholdWide = {1'b0, thresholdReg_q[THS_VALUE_MSB:0]};

    genvar ax;
    generate
        for (ax = 0; ax < NUM_AXES; ax++) begin : g_axis
            // Filter: a simple DC-removal stage; the reference tracks slowly
            // toward the input. A recover read loads the last stored sample at once,
            // so there is no settling after it.
            always_comb begin
                sample_d[ax] = sample_q[ax];
                hpRef_d[ax] = hpRef_q[ax];
                hpOut_d[ax] = hpOut_q[ax];
                // A recover read in a tick cycle must not lose the sample
                if (sampleTick) begin
                    sample_d[ax] = rawIn[ax];
                end
                if (readRecover) begin
                    hpRef_d[ax] = sample_q[ax];
                    hpOut_d[ax] = COUNT_ZERO;
                end else if (sampleTick) begin
                    hpOut_d[ax] = 8'(rawIn[ax] - hpRef_q[ax]);
                    // Nudge reference one LSB toward input
                    if ($signed(rawIn[ax]) > $signed(hpRef_q[ax])) begin
                        hpRef_d[ax] = 8'(hpRef_q[ax] + COUNT_ONE);
                    end else if ($signed(rawIn[ax]) < $signed(hpRef_q[ax])) begin
                        hpRef_d[ax] = 8'(hpRef_q[ax] - COUNT_ONE);
                    end
                end
            end

            // Axis registers
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sample_q[ax] <= RESET_BYTE;
                    hpRef_q[ax] <= RESET_BYTE;
                    hpOut_q[ax] <= RESET_BYTE;
                end else begin
                    sample_q[ax] <= sample_d[ax];
                    hpRef_q[ax] <= hpRef_d[ax];
                    hpOut_q[ax] <= hpOut_d[ax];
                end
            end

            // Comparators on the incoming sample
            assign detectIn[ax] = hpForEvents ? 8'(rawIn[ax] - hpRef_q[ax]) : rawIn[ax];
            assign axisHigh[ax] = magnitude(detectIn[ax]) >= thresholdWide;
            assign axisLow[ax] = magnitude(detectIn[ax]) < thresholdWide;
        end
    endgenerate

    // Enabled event bits in source layout: ZH ZL YH YL XH XL
    wire logic [5:0] enables = configReg_q[5:0];
    wire logic [5:0] conditions = {axisHigh[2], axisLow[2], axisHigh[1], axisLow[1],
                                   axisHigh[0], axisLow[0]};
    wire logic [5:0] firing = conditions & enables;
    wire logic combineAnd = configReg_q[CFG_COMBINE_BIT];
    wire logic latchOn = configReg_q[CFG_LATCH_BIT];
    wire logic counterDecrement = thresholdReg_q[THS_MODE_BIT];
    // AND mode needs at least one enable so an empty config never fires
    wire logic combined = combineAnd ? ((firing == enables) && (enables != 6'h00))
                                     : (firing != 6'h00);

    // Event state
    logic [7:0] durCount_q, durCount_d; // Duration counter in samples
    logic [6:0] source_q, source_d; // Active flag and six axis flags
    logic irq_q, irq_d; // Interrupt request of this source

    // Duration, source and request next state
    always_comb begin
        logic recognized;
        recognized = 1'b0;
        durCount_d = durCount_q;
        source_d = source_q;
        // Source read clears contents and request; a new event below wins
        if (readSource) begin
            source_d = 7'h00;
        end
        // A read in the tick cycle re-opens the latch, so the event still wins
        if (sampleTick && !(latchOn && source_q[SRC_ACTIVE_BIT] && !readSource)) begin
            if (combined) begin
                // Count consecutive samples, saturating at the programmed value
                recognized = (durCount_q >= durationReg_q);
                if (durCount_q < durationReg_q) begin
                    durCount_d = 8'(durCount_q + COUNT_ONE);
                end
            end else if (counterDecrement) begin
                // Spikes are filtered: inactive samples only wind back
                if (durCount_q != COUNT_ZERO) begin
                    durCount_d = 8'(durCount_q - COUNT_ONE);
                end
            end else begin
                durCount_d = COUNT_ZERO;
            end
            if (recognized) begin
                source_d = {1'b1, firing};
            end else if (!latchOn) begin
                source_d = 7'h00;
            end
        end
        irq_d = source_d[SRC_ACTIVE_BIT];
    end

    // Event registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            durCount_q <= COUNT_ZERO;
            source_q <= 7'h00;
            irq_q <= 1'b0;
        end else begin
            durCount_q <= durCount_d;
            source_q <= source_d;
            irq_q <= irq_d;
        end
    end

    // Pin and read-data next values
    logic [7:0] rdata_q, rdata_d;
    logic pin1_q, pin1_d, pin2_q, pin2_d;

    // Read mux and pin routing
    always_comb begin
        rdata_d = rdata_q;
        if (regRead) begin
            case (regAddr)
                ADDR_PIN_CONTROL: rdata_d = pinControl_q;
                ADDR_HP_RECOVER: rdata_d = UNMAPPED_READ; // Dummy value
                ADDR_X_SAMPLE: rdata_d = sample_q[0];
                ADDR_Y_SAMPLE: rdata_d = sample_q[1];
                ADDR_Z_SAMPLE: rdata_d = sample_q[2];
                ADDR_EVENT_CONFIG: rdata_d = configReg_q;
                ADDR_EVENT_SOURCE: rdata_d = {1'b0, source_q};
                ADDR_THRESHOLD: rdata_d = thresholdReg_q;
                ADDR_MIN_DURATION: rdata_d = durationReg_q;
                default: rdata_d = UNMAPPED_READ;
            endcase
        end
        // Pins follow the registered request so they never glitch
        pin1_d = routePin(pinControl_q[ROUTE_PIN1_LSB +: ROUTE_WIDTH], irq_q,
                          source2Irq, dataReady);
        pin2_d = routePin(pinControl_q[ROUTE_PIN2_LSB +: ROUTE_WIDTH], irq_q,
                          source2Irq, dataReady);
    end

    // Output registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= RESET_BYTE;
            pin1_q <= 1'b0;
            pin2_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
        end
    end

    assign regRdata = rdata_q;
    assign xFiltered = hpOut_q[0];
    assign yFiltered = hpOut_q[1];
    assign zFiltered = hpOut_q[2];
    assign inertialIrqOne = irq_q;
    assign irqPin1 = pin1_q;
    assign irqPin2 = pin2_q;

endmodule // ied_inertial_event_detector

/* bench/ied_properties.sv */
// Port assertions for the inertial event detector.
`timescale 1ns/1ps
module ied_checker
    import ied_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic sampleTick,
    input wire logic [7:0] xSample,
    input wire logic [7:0] xFiltered,
    input wire logic inertialIrqOne,
    input wire logic irqPin1,
    input wire logic irqPin2
);
    logic [7:0] cfgQ, thsQ, pinQ, xLastQ; // Shadows of written values and the last X sample
    wire rdSrc = regRead && regAddr == ADDR_EVENT_SOURCE;
    // Shadow registers follow host writes and ticks
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgQ <= 8'h00;
            thsQ <= 8'h00;
            pinQ <= 8'h00;
            xLastQ <= 8'h00;
        end else begin
            if (regWrite && regAddr == ADDR_EVENT_CONFIG) cfgQ <= regWdata;
            if (regWrite && regAddr == ADDR_THRESHOLD) thsQ <= regWdata;
            if (regWrite && regAddr == ADDR_PIN_CONTROL) pinQ <= regWdata;
            if (sampleTick) xLastQ <= xSample;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Tick exclusions avoid the documented event-wins race and the X sample load in the read cycle
    a_src_read_clears: assert property (rdSrc && !sampleTick |=> !inertialIrqOne) else $error("irq not cleared by source read");
    a_hp_recover_zero: assert property (regRead && regAddr == ADDR_HP_RECOVER && !sampleTick |=> xFiltered == 8'h00) else $error("filter not zero after recover");
    a_src_top_bit: assert property (rdSrc |=> !regRdata[7]) else $error("source unused bit set");
    a_rdata_stands: assert property (!regRead |=> $stable(regRdata)) else $error("read data moved");
    a_unmapped_zero: assert property (regRead && (regAddr > ADDR_MIN_DURATION || regAddr < ADDR_PIN_CONTROL) |=> regRdata == UNMAPPED_READ) else $error("unmapped read not zero");
    a_cfg_readback: assert property (regRead && regAddr == ADDR_EVENT_CONFIG |=> regRdata == cfgQ) else $error("config readback wrong");
    a_ths_readback: assert property (regRead && regAddr == ADDR_THRESHOLD |=> regRdata == thsQ) else $error("threshold readback wrong");
    a_x_sample_read: assert property (regRead && regAddr == ADDR_X_SAMPLE && !sampleTick |=> regRdata == xLastQ) else $error("x sample readback wrong");
    a_latch_holds_irq: assert property (cfgQ[CFG_LATCH_BIT] && inertialIrqOne && !regWrite && !rdSrc && !$past(rdSrc) |=> inertialIrqOne) else $error("latched irq dropped");
    a_pin1_source: assert property (pinQ[2:0] == ROUTE_SOURCE1 && $past(pinQ[2:0]) == ROUTE_SOURCE1 |-> irqPin1 == $past(inertialIrqOne)) else $error("pin1 not source1");
    a_pin2_ground: assert property (pinQ[5:3] == ROUTE_GROUND && $past(pinQ[5:3]) == ROUTE_GROUND |-> !irqPin2) else $error("pin2 not grounded");
endmodule // ied_checker

bind ied_inertial_event_detector ied_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
    .regRdata(regRdata), .sampleTick(sampleTick), .xSample(xSample), .xFiltered(xFiltered),
    .inertialIrqOne(inertialIrqOne), .irqPin1(irqPin1), .irqPin2(irqPin2));

/* bench/ied_host_model.sv */
// Host-side register master for the detector register port.
`timescale 1ns/1ps
module ied_host_model (
    input wire logic sys_clk,
    output logic [7:0] regAddr,
    output logic regRead,
    output logic regWrite,
    output logic [7:0] regWdata
);
    // Bus idle from time zero
    initial begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regRead = 1'b0;
        regWrite = 1'b0;
    end
    // One access: strobe for one cycle, then scramble the released lines
    task automatic access(input logic [7:0] a, input logic wrEn, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWdata = d;
        regRead = !wrEn;
        regWrite = wrEn;
        @(negedge sys_clk);
        regRead = 1'b0;
        regWrite = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
    endtask
endmodule // ied_host_model

/* bench/testbench.sv */
// Self-checking testbench for the inertial event detector.
`timescale 1ns/1ps
module testbench import ied_pkg::*;;
    logic sys_clk, reset_n, regRead, regWrite, sampleTick, hpForEvents, source2Irq, dataReady;
    logic [7:0] regAddr, regWdata, regRdata, xSample, ySample, zSample;
    logic [7:0] xFiltered, yFiltered, zFiltered;
    logic inertialIrqOne, irqPin1, irqPin2;
    logic rdSeen = 1'b0; // A read was taken at the last edge
    logic [7:0] expQ[$], adrQ[$]; // Expected read data and its address
    logic [7:0] v, w;
    int failCount = 0;
    int testsRun = 0;
    ied_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regRead(regRead),
        .regWrite(regWrite), .regWdata(regWdata));
    ied_inertial_event_detector dut (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
        .sampleTick(sampleTick), .xSample(xSample), .ySample(ySample), .zSample(zSample),
        .hpForEvents(hpForEvents), .source2Irq(source2Irq), .dataReady(dataReady),
        .xFiltered(xFiltered), .yFiltered(yFiltered), .zFiltered(zFiltered),
        .inertialIrqOne(inertialIrqOne), .irqPin1(irqPin1), .irqPin2(irqPin2));
    // 100 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        testsRun++;
        if (g !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Irq level, sampled one falling edge later so the edge has landed
    task automatic chkIrq(input logic e);
        @(negedge sys_clk);
        cmp8("irq", {7'h00, e}, {7'h00, inertialIrqOne});
        cmp8("irqPin1", {7'h00, e}, {7'h00, irqPin1});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(a, 1'b1, d);
    endtask
    // Note the expectation first, then run the bus cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        adrQ.push_back(a);
        host.access(a, 1'b0, 8'h00);
    endtask
    // One sample pulse, spaced two cycles from the next
    task automatic tick(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        @(negedge sys_clk);
        {xSample, ySample, zSample} = {x, y, z};
        sampleTick = 1'b1;
        @(negedge sys_clk);
        sampleTick = 1'b0;
        {xSample, ySample, zSample} = ~{x, y, z};
        @(negedge sys_clk);
    endtask
    // Pattern of active (0x20) and idle X ticks, oldest in bit 0
    task automatic ticks(input logic [7:0] p, input int n);
        for (int k = 0; k < n; k++) tick(p[k] ? 8'h20 : 8'h00, 8'h00, 8'h00);
    endtask
    // Read results: compare the oldest note when read data lands
    always @(posedge sys_clk) rdSeen <= regRead;
    always @(negedge sys_clk) begin
        if (rdSeen) begin
            if (adrQ[0] != ADDR_HP_RECOVER) cmp8("regRdata", expQ[0], regRdata);
            void'(expQ.pop_front());
            void'(adrQ.pop_front());
        end
    end
    task automatic endSim();
        $display("checks %0d errors %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 260 cycles
    initial begin
        #(20000 * 100);
        failCount++;
        $display("[ERR] watchdog expired");
        endSim();
    end
    initial begin
        reset_n = 1'b0;
        sampleTick = 1'b0;
        {xSample, ySample, zSample} = 24'h00_0000;
        {hpForEvents, source2Irq, dataReady} = 3'b000;
        void'($urandom(54));
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
        rd(ADDR_EVENT_CONFIG, 8'h00);
        rd(ADDR_THRESHOLD, 8'h00);
        rd(8'h40, UNMAPPED_READ);
        wr(ADDR_EVENT_SOURCE, 8'hff);
        rd(ADDR_EVENT_SOURCE, 8'h00);
        wr(ADDR_PIN_CONTROL, 8'h01);
        // Random samples read back, routed inputs toggled
        repeat (4) begin
            {v, w} = 16'($urandom);
            {source2Irq, dataReady} = 2'($urandom);
            tick(v, w, v ^ w);
            rd(ADDR_X_SAMPLE, v);
            rd(ADDR_Y_SAMPLE, w);
            rd(ADDR_Z_SAMPLE, v ^ w);
        end
        wr(ADDR_THRESHOLD, 8'h10);
        rd(ADDR_THRESHOLD, 8'h10);
        // Each enable at the threshold boundary; -16 has magnitude 16
        for (int i = 0; i < 6; i++) begin
            v = i[0] ? 8'hF0 : 8'h0F;
            w = i[0] ? 8'h0F : 8'h10;
            wr(ADDR_EVENT_CONFIG, 8'(1 << i));
            tick(v, v, v);
            chkIrq(1'b1);
            rd(ADDR_EVENT_SOURCE, 8'h40 | 8'(1 << i));
            tick(w, w, w);
            rd(ADDR_EVENT_SOURCE, 8'h00);
        end
        wr(ADDR_EVENT_CONFIG, 8'hAA);
        tick(8'h10, 8'h10, 8'h10);
        rd(ADDR_EVENT_SOURCE, 8'h6A);
        tick(8'h10, 8'h0F, 8'h10);
        rd(ADDR_EVENT_SOURCE, 8'h00);
        wr(ADDR_EVENT_CONFIG, 8'h2A);
        tick(8'h10, 8'h0F, 8'h0F);
        rd(ADDR_EVENT_SOURCE, 8'h42);
        // Latched request survives an idle tick until read
        wr(ADDR_EVENT_CONFIG, 8'h42);
        ticks(8'h01, 2);
        chkIrq(1'b1);
        rd(ADDR_EVENT_SOURCE, 8'h42);
        rd(ADDR_EVENT_SOURCE, 8'h00);
        chkIrq(1'b0);
        // Duration two: three active ticks needed
        wr(ADDR_EVENT_CONFIG, 8'h02);
        wr(ADDR_MIN_DURATION, 8'h02);
        ticks(8'h06, 3);
        chkIrq(1'b0);
        ticks(8'h01, 1);
        chkIrq(1'b1);
        ticks(8'h06, 3);
        chkIrq(1'b0);
        wr(ADDR_THRESHOLD, 8'h90);
        ticks(8'hD8, 8);
        chkIrq(1'b1);
        ticks(8'h00, 1);
        wr(ADDR_MIN_DURATION, 8'h00);
        wr(ADDR_THRESHOLD, 8'h10);
        // Filter recover: filtered level falls to zero, low event follows
        hpForEvents = 1'b1;
        wr(ADDR_EVENT_CONFIG, 8'h01);
        tick(8'h50, 8'h50, 8'h50);
        rd(ADDR_HP_RECOVER, 8'h00);
        cmp8("filtered", 8'h00, xFiltered | yFiltered | zFiltered);
        tick(8'h50, 8'h50, 8'h50);
        rd(ADDR_EVENT_SOURCE, 8'h41);
        hpForEvents = 1'b0;
        // Pin 1 data ready, pin 2 either source; request is idle here
        {source2Irq, dataReady} = 2'b01;
        wr(ADDR_PIN_CONTROL, 8'h1C);
        repeat (2) @(negedge sys_clk);
        cmp8("irqPin1", 8'h01, {7'h00, irqPin1});
        cmp8("irqPin2", 8'h00, {7'h00, irqPin2});
        {source2Irq, dataReady} = 2'b10;
        repeat (2) @(negedge sys_clk);
        cmp8("irqPin1", 8'h00, {7'h00, irqPin1});
        cmp8("irqPin2", 8'h01, {7'h00, irqPin2});
        // Pin 1 source 2, pin 2 grounded
        wr(ADDR_PIN_CONTROL, 8'h02);
        repeat (2) @(negedge sys_clk);
        cmp8("irqPin1", 8'h01, {7'h00, irqPin1});
        cmp8("irqPin2", 8'h00, {7'h00, irqPin2});
        repeat (4) @(negedge sys_clk);
        endSim();
    end
endmodule // testbench
